/* File: aux_far_side.sv */
module aux_far_side #(
    // Shortened clock half period keeps the run short
    parameter int EXT_HALF = 8
) (
    // Clock
    input wire logic clk,
    // Device drives
    input wire logic first_o,
    input wire logic first_oe,
    input wire logic second_o,
    input wire logic second_oe,
    // Trigger source
    input wire logic trig_en,
    input wire logic trig_level,
    // Pin levels
    output logic first_i,
    output logic second_i
);
    int cnt_q = 0;
    logic ext_q = 1'b0;
    // Free running timing clock
    always_ff @(posedge clk) begin
        cnt_q <= (cnt_q == EXT_HALF - 1) ? 0 : cnt_q + 1;
        ext_q <= (cnt_q == EXT_HALF - 1) ? !ext_q : ext_q;
    end
    // Stands for a partner set up alike: same rates, slots and trigger type,
    // configured before this device, with reads led by the controller
    // Pull-up on first pin when nobody drives it
    assign first_i = first_oe ? first_o : (trig_en ? trig_level : 1'b1);
    assign second_i = second_oe ? second_o : ext_q;
endmodule

/* File: aux_pin_edge.sv */
module aux_pin_edge #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Levels in, edges out
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] prev;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (ce) begin
            s_d.prev = level;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Edge per pin
    // ------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_edge
        assign rise[i] = level[i] & ~s_q.prev[i];
        assign fall[i] = ~level[i] & s_q.prev[i];
    end
endmodule

/* File: aux_pin_pkg.sv */
package aux_pin_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_EXT_COUNT = 8'h08;
    localparam logic [7:0] OFS_EVENT_COUNT = 8'h0c;

    // Control word fields
    localparam int CTRL_FUNC_LSB = 0;
    localparam int CTRL_FUNC_W = 4;
    localparam int CTRL_FORCE_BIT = 4;
    localparam logic [3:0] CTRL_FUNC_RESET = 4'h0;

    // Status word fields
    localparam int STAT_FIRST_OE_BIT = 0;
    localparam int STAT_SECOND_OE_BIT = 1;
    localparam int STAT_EXT_TIMING_BIT = 2;
    localparam int STAT_TARGET_BIT = 3;
    localparam int STAT_CONTROLLER_BIT = 4;
    localparam int STAT_RESERVED_BIT = 5;
    localparam int STAT_PENDING_BIT = 6;

    localparam int COUNT_W = 16;

    // ------------------------------------------------------------------
    // Function codes
    // ------------------------------------------------------------------
    localparam logic [3:0] FUNC_MUX_INT = 4'h0;
    localparam logic [3:0] FUNC_MUX_EXT = 4'h1;
    localparam logic [3:0] FUNC_SMP_IN_INT = 4'h2;
    localparam logic [3:0] FUNC_SMP_IN_EXT = 4'h3;
    localparam logic [3:0] FUNC_SMP_OUT_INT = 4'h4;
    localparam logic [3:0] FUNC_SMP_OUT_EXT = 4'h5;
    localparam logic [3:0] FUNC_EXP_IN = 4'h6;
    localparam logic [3:0] FUNC_EXP_OUT_INT = 4'h7;
    localparam logic [3:0] FUNC_EXP_OUT_EXT = 4'h8;
    localparam logic [3:0] FUNC_PIN_SYNC = 4'h9;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // From the exposure sequencer
    typedef struct packed {
        logic mux_states_enabled;
        logic high_bank_exposure;
        logic sample_level;
        logic exposure_level;
        logic osc_tick;
    } seq_status_t;

    // To the exposure sequencer
    typedef struct packed {
        logic timebase_tick;
        logic sample_trigger;
        logic exposure_trigger;
        logic seq_abort;
        logic seq_restart;
        logic ext_timing;
        logic trigger_timing;
    } seq_ctrl_t;

    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;

    typedef enum logic [0:0] {
        SYNC_IDLE,
        SYNC_WAIT_CLK
    } sync_state_t;

endpackage

/* File: aux_pin_sync_select.sv */
// Operation
// RULE1 - Mux pin drives low on LED4-6 exposures, high otherwise, when states A-C used.
// RULE2 - Mux pin floats when no A, B or C state is in the sequence.
// RULE3 - Code 0000: first pin mux, second disabled, internal oscillator timing.
// RULE4 - Code 0001: first pin mux, second pin external clock sets all timing.
// RULE5 - Code 0010: first pin sample trigger input, second mux, internal timing.
// RULE6 - Code 0011: first pin sample trigger input, second pin external clock.
// RULE7 - Codes 0100/0101: first pin drives sample timing; 0100 mux, 0101 external clock.
// RULE8 - Code 0110: first pin exposure trigger sets all timing, second pin mux.
// RULE9 - Codes 0111/1000: first pin drives exposure timing; 0111 internal, 1000 external.
// RULE10 - Code 1001: first pin fall aborts, restart on next second pin rise.
// RULE11 - Paired devices share rate, integration, averaging, timestamp and FIFO settings.
// RULE12 - Paired devices use equal slot counts and matching ambient slot positions.
// RULE13 - Both use the same trigger type; configure target before controller.
// RULE14 - Interrupt only on controller; read controller then target, equal counts.
// RULE15 - Codes above 1001 are reserved; both pins stay undriven.
//
// The APB slave port and the register addresses are this design's own decisions.
module aux_pin_sync_select
    import aux_pin_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CE,
    // APB slave
    input wire aux_pin_pkg::apb_req_t APB_REQ,
    output aux_pin_pkg::apb_rsp_t APB_RSP,
    // Sequencer side
    input wire aux_pin_pkg::seq_status_t SEQ_STATUS,
    output aux_pin_pkg::seq_ctrl_t SEQ_CTRL,
    // First auxiliary pin
    input wire logic FIRST_AUX_PIN_I,
    output logic FIRST_AUX_PIN_O,
    output logic FIRST_AUX_PIN_OE,
    // Second auxiliary pin
    input wire logic SECOND_AUX_PIN_I,
    output logic SECOND_AUX_PIN_O,
    output logic SECOND_AUX_PIN_OE
);
    import aux_pin_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] func;
        logic force_req;
        sync_state_t sync;
        logic [COUNT_W-1:0] ext_count;
        logic [COUNT_W-1:0] event_count;
        apb_rsp_t rsp;
        seq_ctrl_t ctrl;
        pin_drive_t first;
        pin_drive_t second;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    aux_pin_edge #(
        .W(2)
    ) u_edge (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .ce(CE),
        .level({SECOND_AUX_PIN_I, FIRST_AUX_PIN_I}),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ------------------------------------------------------------------
    // Decode of the function code
    // ------------------------------------------------------------------
    logic first_is_mux;
    logic first_smp_in;
    logic first_exp_in;
    logic first_smp_out;
    logic first_exp_out;
    logic first_sync_in;
    logic second_is_mux;
    logic second_is_clk;
    logic code_reserved;
    pin_drive_t mux_drive;

    always_comb begin
        first_is_mux = 1'b0;
        first_smp_in = 1'b0;
        first_exp_in = 1'b0;
        first_smp_out = 1'b0;
        first_exp_out = 1'b0;
        first_sync_in = 1'b0;
        second_is_mux = 1'b0;
        second_is_clk = 1'b0;
        code_reserved = 1'b0;
        unique case (s_q.func)
            FUNC_MUX_INT: begin
                first_is_mux = 1'b1; // RULE3
            end
            FUNC_MUX_EXT: begin
                first_is_mux = 1'b1; // RULE4
                second_is_clk = 1'b1; // RULE4
            end
            FUNC_SMP_IN_INT: begin
                first_smp_in = 1'b1; // RULE5
                second_is_mux = 1'b1; // RULE5
            end
            FUNC_SMP_IN_EXT: begin
                first_smp_in = 1'b1; // RULE6
                second_is_clk = 1'b1; // RULE6
            end
            FUNC_SMP_OUT_INT: begin
                first_smp_out = 1'b1; // RULE7
                second_is_mux = 1'b1; // RULE7
            end
            FUNC_SMP_OUT_EXT: begin
                first_smp_out = 1'b1; // RULE7
                second_is_clk = 1'b1; // RULE7
            end
            FUNC_EXP_IN: begin
                first_exp_in = 1'b1; // RULE8
                second_is_mux = 1'b1; // RULE8
            end
            FUNC_EXP_OUT_INT: begin
                first_exp_out = 1'b1; // RULE9
                second_is_mux = 1'b1; // RULE9
            end
            FUNC_EXP_OUT_EXT: begin
                first_exp_out = 1'b1; // RULE9
                second_is_clk = 1'b1; // RULE9
            end
            FUNC_PIN_SYNC: begin
                first_sync_in = 1'b1; // RULE10
                second_is_clk = 1'b1; // RULE10
            end
            default: begin
                // Undefined codes leave both pins floating
                code_reserved = 1'b1; // RULE15
            end
        endcase
    end

    // Mux control level; floats unless states A-C are in the sequence
    always_comb begin
        mux_drive.oe = SEQ_STATUS.mux_states_enabled; // RULE2
        mux_drive.o = ~SEQ_STATUS.high_bank_exposure; // RULE1
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic apb_setup;
    logic apb_wr;
    logic addr_hit;
    logic [31:0] rd_word;

    assign apb_setup = APB_REQ.psel & ~APB_REQ.penable;
    assign apb_wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & s_q.rsp.pready;

    always_comb begin
        rd_word = '0;
        addr_hit = 1'b1;
        unique case (APB_REQ.paddr)
            OFS_CTRL: begin
                rd_word[CTRL_FUNC_LSB +: CTRL_FUNC_W] = s_q.func;
            end
            OFS_STATUS: begin
                rd_word[STAT_FIRST_OE_BIT] = s_q.first.oe;
                rd_word[STAT_SECOND_OE_BIT] = s_q.second.oe;
                rd_word[STAT_EXT_TIMING_BIT] = s_q.ctrl.ext_timing;
                rd_word[STAT_TARGET_BIT] = first_smp_in | first_exp_in;
                rd_word[STAT_CONTROLLER_BIT] = first_smp_out | first_exp_out;
                rd_word[STAT_RESERVED_BIT] = code_reserved;
                rd_word[STAT_PENDING_BIT] = (s_q.sync == SYNC_WAIT_CLK);
            end
            OFS_EXT_COUNT: begin
                rd_word[COUNT_W-1:0] = s_q.ext_count;
            end
            OFS_EVENT_COUNT: begin
                rd_word[COUNT_W-1:0] = s_q.event_count;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic ext_edge;
    logic trig_event;

    always_comb begin
        s_d = s_q;
        ext_edge = second_is_clk & pin_rise[1];
        trig_event = 1'b0;
        if (CE) begin
            // Register access: answer one cycle after setup, zero wait states
            s_d.rsp.pready = apb_setup;
            s_d.rsp.pslverr = apb_setup & ~addr_hit;
            s_d.rsp.prdata = (apb_setup & ~APB_REQ.pwrite) ? rd_word : '0;
            s_d.force_req = 1'b0;
            if (apb_wr && APB_REQ.paddr == OFS_CTRL) begin
                s_d.func = APB_REQ.pwdata[CTRL_FUNC_LSB +: CTRL_FUNC_W];
                // Self-clearing; never read back
                s_d.force_req = APB_REQ.pwdata[CTRL_FORCE_BIT];
            end

            // Timebase selection
            s_d.ctrl.ext_timing = second_is_clk; // RULE4
            s_d.ctrl.trigger_timing = first_exp_in; // RULE8
            if (first_exp_in) begin
                // Exposure trigger paces samples and exposures alike
                s_d.ctrl.timebase_tick = pin_rise[0]; // RULE8
            end else if (second_is_clk) begin
                s_d.ctrl.timebase_tick = ext_edge; // RULE4 RULE6 RULE10
            end else begin
                s_d.ctrl.timebase_tick = SEQ_STATUS.osc_tick; // RULE3 RULE5
            end
            if (ext_edge) begin
                s_d.ext_count = s_q.ext_count + 1'b1;
            end

            // Target role triggers
            s_d.ctrl.sample_trigger = first_smp_in & pin_rise[0]; // RULE5 RULE6
            s_d.ctrl.exposure_trigger = first_exp_in & pin_rise[0]; // RULE8

            // Forced resync from the pin, held until the clock edge
            s_d.ctrl.seq_abort = 1'b0;
            s_d.ctrl.seq_restart = 1'b0;
            unique case (s_q.sync)
                SYNC_IDLE: begin
                    if (first_sync_in && pin_fall[0]) begin
                        s_d.ctrl.seq_abort = 1'b1; // RULE10
                        s_d.sync = SYNC_WAIT_CLK;
                    end
                end
                SYNC_WAIT_CLK: begin
                    if (!first_sync_in) begin
                        // Leaving the mode drops a pending restart
                        s_d.sync = SYNC_IDLE;
                    end else if (ext_edge) begin
                        s_d.ctrl.seq_restart = 1'b1; // RULE10
                        s_d.sync = SYNC_IDLE;
                    end
                end
            endcase
            // Software resync aborts and restarts at once
            if (s_q.force_req) begin
                s_d.ctrl.seq_abort = 1'b1;
                s_d.ctrl.seq_restart = 1'b1;
            end

            trig_event = s_d.ctrl.sample_trigger | s_d.ctrl.exposure_trigger
                | s_d.ctrl.seq_restart;
            if (trig_event) begin
                s_d.event_count = s_q.event_count + 1'b1;
            end

            // First pin drive
            if (first_is_mux) begin
                s_d.first = mux_drive; // RULE1 RULE2
            end else if (first_smp_out) begin
                s_d.first.oe = 1'b1; // RULE7
                s_d.first.o = SEQ_STATUS.sample_level; // RULE7
            end else if (first_exp_out) begin
                s_d.first.oe = 1'b1; // RULE9
                s_d.first.o = SEQ_STATUS.exposure_level; // RULE9
            end else begin
                // Inputs, pin sync and reserved codes
                s_d.first = '0; // RULE15
            end

            // Second pin drive; disabled or clock input otherwise
            if (second_is_mux) begin
                s_d.second = mux_drive; // RULE1 RULE2
            end else begin
                s_d.second = '0; // RULE3 RULE15
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            s_q.func <= CTRL_FUNC_RESET;
            s_q.force_req <= 1'b0;
            s_q.sync <= SYNC_IDLE;
            s_q.ext_count <= '0;
            s_q.event_count <= '0;
            s_q.rsp <= '0;
            s_q.ctrl <= '0;
            s_q.first <= '0;
            s_q.second <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------------
    assign APB_RSP = s_q.rsp;
    assign SEQ_CTRL = s_q.ctrl;
    assign FIRST_AUX_PIN_O = s_q.first.o;
    assign FIRST_AUX_PIN_OE = s_q.first.oe;
    assign SECOND_AUX_PIN_O = s_q.second.o;
    assign SECOND_AUX_PIN_OE = s_q.second.oe;
endmodule

/* File: aux_pin_sync_select_properties.sv */
module aux_pin_sync_select_properties
    import aux_pin_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CE,
    // Bus and sequencer
    input wire aux_pin_pkg::apb_req_t APB_REQ,
    input wire aux_pin_pkg::apb_rsp_t APB_RSP,
    input wire aux_pin_pkg::seq_status_t SEQ_STATUS,
    input wire aux_pin_pkg::seq_ctrl_t SEQ_CTRL,
    // Pins
    input wire logic FIRST_AUX_PIN_I,
    input wire logic FIRST_AUX_PIN_O,
    input wire logic FIRST_AUX_PIN_OE,
    input wire logic SECOND_AUX_PIN_I,
    input wire logic SECOND_AUX_PIN_O,
    input wire logic SECOND_AUX_PIN_OE
);
    // ----
    // Shadow of the function code, taken from completed writes
    // ----
    logic [3:0] code_q;
    logic [3:0] code_d;
    always_comb begin
        code_d = code_q;
        if (CE && APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && APB_REQ.pwrite
            && APB_REQ.paddr == OFS_CTRL) begin
            code_d = APB_REQ.pwdata[3:0];
        end
    end
    always_ff @(posedge CLK_SYS) begin
        code_q <= !RSTN ? CTRL_FUNC_RESET : code_d;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // ----
    // Pin roles
    // ----
    a_mux_first_pin: assert property (
        CE && code_q inside {4'h0, 4'h1} |=> FIRST_AUX_PIN_OE == $past(SEQ_STATUS.mux_states_enabled)
        && (!FIRST_AUX_PIN_OE || FIRST_AUX_PIN_O == !$past(SEQ_STATUS.high_bank_exposure)))
        else $error("first pin mux drive wrong");
    a_second_off: assert property (
        CE && code_q == FUNC_MUX_INT |=> !SECOND_AUX_PIN_OE) else $error("second pin driven");
    a_mux_second_pin: assert property (
        CE && code_q inside {4'h2, 4'h4, 4'h6, 4'h7} |=> SECOND_AUX_PIN_OE ==
        $past(SEQ_STATUS.mux_states_enabled)
        && (!SECOND_AUX_PIN_OE || SECOND_AUX_PIN_O == !$past(SEQ_STATUS.high_bank_exposure)))
        else $error("second pin mux drive wrong");
    a_clock_second_in: assert property (
        CE && code_q inside {4'h1, 4'h3, 4'h5, 4'h8, 4'h9} |=> !SECOND_AUX_PIN_OE
        && SEQ_CTRL.ext_timing) else $error("external clock mode wrong");
    a_smp_trigger_in: assert property (
        CE && code_q inside {4'h2, 4'h3} && $rose(FIRST_AUX_PIN_I) |=> SEQ_CTRL.sample_trigger
        && !FIRST_AUX_PIN_OE) else $error("sample trigger missed");
    a_exp_trigger_in: assert property (
        CE && code_q == FUNC_EXP_IN && $rose(FIRST_AUX_PIN_I) |=> SEQ_CTRL.exposure_trigger
        && SEQ_CTRL.timebase_tick) else $error("exposure trigger missed");
    a_smp_drive_out: assert property (
        CE && code_q inside {4'h4, 4'h5} |=> FIRST_AUX_PIN_OE
        && FIRST_AUX_PIN_O == $past(SEQ_STATUS.sample_level)) else $error("sample out wrong");
    a_exp_drive_out: assert property (
        CE && code_q inside {4'h7, 4'h8} |=> FIRST_AUX_PIN_OE
        && FIRST_AUX_PIN_O == $past(SEQ_STATUS.exposure_level)) else $error("exposure out wrong");
    a_sync_abort_cause: assert property (
        SEQ_CTRL.seq_abort && !SEQ_CTRL.seq_restart |-> $past(code_q) == FUNC_PIN_SYNC
        && $past(FIRST_AUX_PIN_I, 2) && !$past(FIRST_AUX_PIN_I)) else $error("stray abort");
    a_sync_restart_cause: assert property (
        SEQ_CTRL.seq_restart && !SEQ_CTRL.seq_abort |-> !$past(SECOND_AUX_PIN_I, 2)
        && $past(SECOND_AUX_PIN_I) && SEQ_CTRL.timebase_tick) else $error("stray restart");
    a_reserved_float: assert property (
        CE && code_q > FUNC_PIN_SYNC |=> !FIRST_AUX_PIN_OE && !SECOND_AUX_PIN_OE)
        else $error("reserved code drives a pin");
endmodule

bind aux_pin_sync_select aux_pin_sync_select_properties u_props (.CLK_SYS(CLK_SYS),
    .RSTN(RSTN), .CE(CE), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .SEQ_STATUS(SEQ_STATUS),
    .SEQ_CTRL(SEQ_CTRL), .FIRST_AUX_PIN_I(FIRST_AUX_PIN_I), .FIRST_AUX_PIN_O(FIRST_AUX_PIN_O),
    .FIRST_AUX_PIN_OE(FIRST_AUX_PIN_OE), .SECOND_AUX_PIN_I(SECOND_AUX_PIN_I),
    .SECOND_AUX_PIN_O(SECOND_AUX_PIN_O), .SECOND_AUX_PIN_OE(SECOND_AUX_PIN_OE));

/* File: testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import aux_pin_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    seq_status_t st = '0;
    seq_ctrl_t sc;
    logic f_i, f_o, f_oe, s_i, s_o, s_oe;
    logic trig_en = 1'b0;
    logic trig_lv = 1'b1;
    logic [31:0] rd;
    logic err;
    logic [3:0] tc [5] = '{4'h2, 4'h3, 4'h6, 4'h0, 4'hc};
    int n_fail = 0, n_compared = 0, n_smp = 0, n_exp = 0, n_abt = 0, n_rst = 0;
    int s0, e0;
    initial forever #5 clk = !clk;
    aux_pin_sync_select u_aux_pin_sync_select (.CLK_SYS(clk), .RSTN(rstn), .CE(ce),
        .APB_REQ(req), .APB_RSP(rsp), .SEQ_STATUS(st), .SEQ_CTRL(sc),
        .FIRST_AUX_PIN_I(f_i), .FIRST_AUX_PIN_O(f_o), .FIRST_AUX_PIN_OE(f_oe),
        .SECOND_AUX_PIN_I(s_i), .SECOND_AUX_PIN_O(s_o), .SECOND_AUX_PIN_OE(s_oe));
    aux_far_side #(.EXT_HALF(8)) u_aux_far_side (.clk(clk), .first_o(f_o), .first_oe(f_oe),
        .second_o(s_o), .second_oe(s_oe), .trig_en(trig_en), .trig_level(trig_lv),
        .first_i(f_i), .second_i(s_i));
    always @(posedge clk) begin
        n_smp += (sc.sample_trigger === 1'b1);
        n_exp += (sc.exposure_trigger === 1'b1);
        n_abt += (sc.seq_abort === 1'b1);
        n_rst += (sc.seq_restart === 1'b1);
    end
    task check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // Idle cycle first, so no signal is driven twice in one step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1 && n++ < 20);
        // A slave that never answers counts against the run
        if (rsp.pready !== 1'b1) begin
            n_fail++;
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    function automatic logic [1:0] exp_oe(input logic [3:0] c);
        exp_oe[0] = c inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h7, 4'h8};
        exp_oe[1] = c inside {4'h2, 4'h4, 4'h6, 4'h7};
    endfunction
    task summarize;
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize;
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check({rd[30:0], err}, 32'h1);
        // ----
        // Mux level follows the bank, then floats
        // ----
        st.mux_states_enabled <= 1'b1;
        for (int h = 0; h < 2; h++) begin
            st.high_bank_exposure <= h[0];
            repeat (3) @(posedge clk);
            check({f_oe, f_i, s_oe}, {1'b1, !h[0], 1'b0});
        end
        st.mux_states_enabled <= 1'b0;
        repeat (3) @(posedge clk);
        check({f_oe, f_i}, 2'b01);
        // ----
        // Every code: directions, timing source, reserved flag
        // ----
        st <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, OFS_CTRL, 32'(c));
            apb(1'b0, OFS_CTRL, 32'h0);
            check(rd, 32'(c));
            check({s_oe, f_oe}, exp_oe(c[3:0]));
            check(f_i, !(c inside {7, 8}));
            check(sc.ext_timing, c inside {1, 3, 5, 8, 9});
            check(sc.trigger_timing, c == 6);
            apb(1'b0, OFS_STATUS, 32'h0);
            check(rd, {25'h0, 1'b0, c > 9, c inside {4, 5, 7, 8}, c inside {2, 3, 6},
                c inside {1, 3, 5, 8, 9}, exp_oe(c[3:0])});
        end
        // ----
        // Triggers count only in the matching role
        // ----
        trig_en <= 1'b1;
        trig_lv <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, OFS_CTRL, {28'h0, tc[k]});
            repeat (2) @(posedge clk);
            s0 = n_smp;
            e0 = n_exp;
            trig_lv <= 1'b1;
            repeat (2) @(posedge clk);
            trig_lv <= 1'b0;
            repeat (4) @(posedge clk);
            check(n_smp - s0, tc[k] inside {4'h2, 4'h3});
            check(n_exp - e0, tc[k] == 4'h6);
        end
        // ----
        // Pin resync: one abort, one restart, second fall ignored
        // ----
        apb(1'b1, OFS_CTRL, 32'h9);
        trig_lv <= 1'b1;
        @(posedge s_i);
        @(posedge clk);
        s0 = n_abt;
        e0 = n_rst;
        for (int k = 0; k < 3; k++) begin
            trig_lv <= k[0];
            repeat (2) @(posedge clk);
        end
        repeat (20) @(posedge clk);
        check(n_abt - s0, 32'h1);
        check(n_rst - e0, 32'h1);
        // Software resync bit pulses both and reads back clear
        s0 = n_abt;
        apb(1'b1, OFS_CTRL, 32'h10);
        repeat (4) @(posedge clk);
        check(n_abt - s0, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        // Enable low freezes the edge detector: a pulse inside it is lost
        apb(1'b1, OFS_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        trig_lv <= 1'b1;
        repeat (3) @(posedge clk);
        trig_lv <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        // Two sample, one exposure, one pin restart, one software restart
        apb(1'b0, OFS_EVENT_COUNT, 32'h0);
        check(rd, 32'h5);
        summarize;
    end
endmodule
